// [txss_pkg.sv]
`default_nettype none
package txss_pkg;

  // Register addresses on the 8-bit register port.
  localparam logic [7:0] TXSS_ADDR_METER_LO = 8'h18;
  localparam logic [7:0] TXSS_ADDR_METER_HI = 8'h19;
  localparam logic [7:0] TXSS_ADDR_TIMER_CTL = 8'h1a;
  localparam logic [7:0] TXSS_ADDR_STATUS = 8'h1b;
  localparam logic [7:0] TXSS_ADDR_MODE = 8'h0b;
  localparam logic [7:0] TXSS_ADDR_TRIM = 8'h28;
  localparam logic [7:0] TXSS_ADDR_LEVEL = 8'h29;

  // Field positions in tx_mode_control.
  localparam int TXSS_MODE_SRC_LSB = 0;
  localparam int TXSS_MODE_REMOTE_BIT = 3;
  localparam int TXSS_MODE_OFF_BIT = 4;
  localparam int TXSS_MODE_LVL_LSB = 5;

  // Field positions in the timer control register.
  localparam int TXSS_TCTL_EN_BIT = 0;
  localparam int TXSS_TCTL_CONT_BIT = 1;

  // Field positions in the status register.
  localparam int TXSS_STAT_ZERO_BIT = 0;
  localparam int TXSS_STAT_SIGN_BIT = 1;
  localparam int TXSS_STAT_MAG_BIT = 2;
  localparam int TXSS_STAT_RUN_BIT = 3;
  localparam int TXSS_STAT_PHASE_BIT = 4;

  // Reset values.
  localparam logic [7:0] TXSS_MODE_RESET = 8'h12;
  localparam logic [7:0] TXSS_LEVEL_RESET = 8'h00;
  localparam logic [7:0] TXSS_TCTL_RESET = 8'h00;
  localparam logic [15:0] TXSS_METER_RESET = 16'hffff;
  localparam logic [22:0] TXSS_LFSR_RESET = 23'h00_0000;

  // Source select codes.
  localparam logic [2:0] TXSS_SRC_PULSE = 3'h0;
  localparam logic [2:0] TXSS_SRC_LOOP_SCR = 3'h1;
  localparam logic [2:0] TXSS_SRC_DATA_RAW = 3'h2;
  localparam logic [2:0] TXSS_SRC_ONES_SCR = 3'h3;
  localparam logic [2:0] TXSS_SRC_ALT = 3'h4;
  localparam logic [2:0] TXSS_SRC_DATA_SCR = 3'h5;
  localparam logic [2:0] TXSS_SRC_DATA_2LVL = 3'h6;
  localparam logic [2:0] TXSS_SRC_ONES_2LVL = 3'h7;

  // Scrambler tap positions, counted from one.
  localparam int TXSS_LFSR_LEN = 23;
  localparam int TXSS_TAP_LOCAL = 5;
  localparam int TXSS_TAP_REMOTE = 18;

  typedef struct packed {
    logic sign;
    logic mag;
  } txss_pair_s;

  typedef struct packed {
    logic zero;
    txss_pair_s pair;
  } txss_sym_s;

endpackage
`default_nettype wire

// [txss_meter_timer.sv]
`timescale 1ns/1ns
`default_nettype none
module txss_meter_timer
  import txss_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic enable,
  input wire logic continuous,
  input wire logic restart,
  input wire logic [15:0] interval,
  output logic tick,
  output logic running
);

  logic [15:0] count;
  logic done;
  wire expire = running && (count == 16'h0000);
  wire [15:0] reload = (interval == 16'h0000) ? 16'h0000 : interval - 16'h0001;

  // A one-shot run stays finished until software restarts the timer.
  always_ff @(posedge ref_clk)
  begin
    if (rst || restart || !enable)
    begin
      count <= reload;
      done <= 1'b0;
      tick <= 1'b0;
    end
    else
    begin
      tick <= expire;
      if (expire)
      begin
        count <= reload;
        done <= !continuous;
      end
      else if (running)
      begin
        count <= count - 16'h0001;
      end
    end
  end

  assign running = enable && !done;

endmodule
`default_nettype wire

// [txss_top.sv]
// What this block does
// - Source 000 sends timer-paced isolated test pulses.
// - Source 001 scrambles and returns detector bits.
// - Source 010 sends channel bits unscrambled.
// - Source 011 sends scrambled constant ones.
// - Source 100 alternates polarity each timer interval.
// - Source 101 sends scrambled channel bits.
// - Source 110 sends channel sign, magnitude zero.
// - Source 111 scrambles ones once per symbol.
// - Sign then magnitude map to four levels.
// - Two-level modes use sign only, outer levels.
// - 23-stage scrambler, taps 5 or 18.
// - Scrambler steps once or twice per symbol.
// - Output-off bit forces zero symbol.
// - Zero level only in pulse or off.
// - Pulse is one nonzero symbol between zeros.
// - Converter levels scaled by level register.
// - Timer interval is sixteen bits, two registers.
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/1ns
`default_nettype none
module txss_top
  import txss_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire txss_pair_s cu_pair,
  input wire txss_pair_s det_pair,
  input wire logic [7:0] factory_trim_pin,
  output txss_sym_s dac_symbol,
  output logic [7:0] dac_level,
  output logic signed [11:0] dac_sample
);

  // One ref_clk cycle is one transmitted symbol.

  // One scrambler step: returns the next state over the output bit.
  function automatic logic [23:0] scr_step(
    input logic [22:0] st,
    input logic in_bit,
    input logic remote
  );
    logic fb;
    logic out_bit;
    fb = st[TXSS_LFSR_LEN - 1] ^
      (remote ? st[TXSS_TAP_REMOTE - 1] : st[TXSS_TAP_LOCAL - 1]);
    out_bit = in_bit ^ fb;
    scr_step = {st[21:0], out_bit, out_bit};
  endfunction

  // Normalised line level of a symbol: +3, +1, -1, -3 or zero.
  function automatic logic signed [2:0] sym_value(input txss_sym_s s);
    logic signed [2:0] v;
    v = 3'sd0;
    if (!s.zero)
    begin
      unique case ({s.pair.sign, s.pair.mag})
        2'b00: v = -3'sd3;
        2'b01: v = -3'sd1;
        2'b11: v = 3'sd1;
        2'b10: v = 3'sd3;
      endcase
    end
    sym_value = v;
  endfunction

  // A strobe that lands on one register address.
  function automatic logic reg_hit(
    input logic strobe,
    input logic [7:0] addr,
    input logic [7:0] target
  );
    reg_hit = strobe && (addr == target);
  endfunction

  logic [7:0] tx_mode_control;
  logic [7:0] dac_level_adjust;
  logic [7:0] timer_ctl;
  logic [15:0] meter_interval;
  logic [7:0] trim_meta;
  logic [7:0] factory_level_trim;
  logic [7:0] act_mode;
  logic [22:0] lfsr;
  logic alt_phase;
  txss_sym_s last_sym;

  wire timer_tick;
  wire timer_running;

  // Write decode.
  wire wr_mode = reg_hit(reg_wr, reg_addr, TXSS_ADDR_MODE);
  wire wr_level = reg_hit(reg_wr, reg_addr, TXSS_ADDR_LEVEL);
  wire wr_meter_lo = reg_hit(reg_wr, reg_addr, TXSS_ADDR_METER_LO);
  wire wr_meter_hi = reg_hit(reg_wr, reg_addr, TXSS_ADDR_METER_HI);
  wire wr_tctl = reg_hit(reg_wr, reg_addr, TXSS_ADDR_TIMER_CTL);
  wire timer_restart = wr_meter_lo || wr_meter_hi || wr_tctl;

  // Mode fields as seen by the symbol path, taken from the snapshot.
  wire [2:0] src = act_mode[TXSS_MODE_SRC_LSB +: 3];
  wire remote = act_mode[TXSS_MODE_REMOTE_BIT];
  wire tx_off = act_mode[TXSS_MODE_OFF_BIT];
  wire [1:0] lvl = act_mode[TXSS_MODE_LVL_LSB +: 2];
  wire txss_pair_s lvl_pair = '{sign: lvl[1], mag: lvl[0]};

  // Input bit pair for the scrambler and the direct paths.
  wire use_det = (src == TXSS_SRC_LOOP_SCR);
  wire use_ones = (src == TXSS_SRC_ONES_SCR) ||
    (src == TXSS_SRC_ONES_2LVL);
  wire txss_pair_s in_pair = use_ones ? txss_pair_s'(2'b11) :
    (use_det ? det_pair : cu_pair);

  // Two chained steps: sign bit first, then magnitude bit.
  wire [23:0] step_a = scr_step(lfsr, in_pair.sign, remote);
  wire [23:0] step_b = scr_step(step_a[23:1], in_pair.mag, remote);

  wire four_scr = (src == TXSS_SRC_LOOP_SCR) ||
    (src == TXSS_SRC_ONES_SCR) || (src == TXSS_SRC_DATA_SCR);
  wire two_scr = (src == TXSS_SRC_ONES_2LVL);

  // The scrambler holds still in modes that do not use it.
  wire [22:0] next_lfsr = four_scr ? step_b[23:1] :
    (two_scr ? step_a[23:1] : lfsr);

  // Pulse mode refuses a pulse right after a nonzero symbol, so a
  // short timer interval can never merge two pulses.
  wire pulse_fire = timer_tick && last_sym.zero;

  wire next_alt_phase = (src == TXSS_SRC_ALT) ?
    (alt_phase ^ timer_tick) : 1'b0;

  txss_sym_s src_sym;
  always_comb
  begin
    src_sym = '{zero: 1'b0, pair: in_pair};
    unique case (src)
      TXSS_SRC_PULSE:
      begin
        src_sym.zero = !pulse_fire;
        src_sym.pair = lvl_pair;
      end
      TXSS_SRC_LOOP_SCR, TXSS_SRC_ONES_SCR, TXSS_SRC_DATA_SCR:
      begin
        src_sym.pair.sign = step_a[0];
        src_sym.pair.mag = step_b[0];
      end
      TXSS_SRC_DATA_RAW:
      begin
        src_sym.pair = cu_pair;
      end
      TXSS_SRC_ALT:
      begin
        // Flipping only the sign bit negates the level.
        src_sym.pair.sign = lvl_pair.sign ^ alt_phase;
        src_sym.pair.mag = lvl_pair.mag;
      end
      TXSS_SRC_DATA_2LVL:
      begin
        src_sym.pair.sign = cu_pair.sign;
        src_sym.pair.mag = 1'b0;
      end
      TXSS_SRC_ONES_2LVL:
      begin
        src_sym.pair.sign = step_a[0];
        src_sym.pair.mag = 1'b0;
      end
    endcase
  end

  wire txss_sym_s next_sym = tx_off ?
    '{zero: 1'b1, pair: 2'b00} : src_sym;

  // The level word is applied to the sample of the same symbol.
  // Both factors are widened to the sample width first, so the
  // product of a 3-bit level and an 8-bit gain cannot wrap.
  wire signed [2:0] sym_val = sym_value(next_sym);
  wire signed [11:0] sym_val_wide = {{9{sym_val[2]}}, sym_val};
  wire signed [11:0] gain_wide = {4'h0, dac_level_adjust};
  wire signed [11:0] next_sample = sym_val_wide * gain_wide;

  // Read decode.
  wire [7:0] status_word = {3'b000, alt_phase, timer_running,
    last_sym.pair.mag, last_sym.pair.sign, last_sym.zero};
  logic [7:0] next_rdata;
  always_comb
  begin
    next_rdata = 8'h00;
    if (reg_rd)
    begin
      unique case (reg_addr)
        TXSS_ADDR_MODE: next_rdata = tx_mode_control;
        TXSS_ADDR_TRIM: next_rdata = factory_level_trim;
        TXSS_ADDR_LEVEL: next_rdata = dac_level_adjust;
        TXSS_ADDR_METER_LO: next_rdata = meter_interval[7:0];
        TXSS_ADDR_METER_HI: next_rdata = meter_interval[15:8];
        TXSS_ADDR_TIMER_CTL: next_rdata = timer_ctl;
        TXSS_ADDR_STATUS: next_rdata = status_word;
        default: next_rdata = 8'h00;
      endcase
    end
  end

  // Each register has its own short process; the writes are decoded
  // above, so a block only chooses between reset, write and hold.
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      tx_mode_control <= TXSS_MODE_RESET;
    end
    else if (wr_mode)
    begin
      tx_mode_control <= reg_wdata;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      dac_level_adjust <= TXSS_LEVEL_RESET;
    end
    else if (wr_level)
    begin
      dac_level_adjust <= reg_wdata;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      timer_ctl <= TXSS_TCTL_RESET;
    end
    else if (wr_tctl)
    begin
      timer_ctl <= reg_wdata;
    end
  end

  // Writing either half restarts the timer, but the restart reloads the interval held
  // before that write; the new value is used from the next reload on.
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      meter_interval <= TXSS_METER_RESET;
    end
    else
    begin
      if (wr_meter_lo)
      begin
        meter_interval[7:0] <= reg_wdata;
      end
      if (wr_meter_hi)
      begin
        meter_interval[15:8] <= reg_wdata;
      end
    end
  end

  // Read data stand for one cycle after the strobe, zero otherwise.
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      reg_rdata <= 8'h00;
    end
    else
    begin
      reg_rdata <= next_rdata;
    end
  end

  // The trim value is a static pin word, but still crosses two stages.
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      trim_meta <= 8'h00;
      factory_level_trim <= 8'h00;
    end
    else
    begin
      trim_meta <= factory_trim_pin;
      factory_level_trim <= trim_meta;
    end
  end

  // Symbol path. The mode snapshot is taken once per symbol, so the
  // bits of one symbol always come from one source selection.
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      act_mode <= TXSS_MODE_RESET;
      lfsr <= TXSS_LFSR_RESET;
      alt_phase <= 1'b0;
      last_sym <= '{zero: 1'b1, pair: 2'b00};
    end
    else
    begin
      act_mode <= tx_mode_control;
      lfsr <= next_lfsr;
      alt_phase <= next_alt_phase;
      last_sym <= next_sym;
    end
  end

  // Converter outputs; symbol and sample leave on the same edge.
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      dac_symbol <= '{zero: 1'b1, pair: 2'b00};
      dac_level <= TXSS_LEVEL_RESET;
      dac_sample <= 12'sd0;
    end
    else
    begin
      dac_symbol <= next_sym;
      dac_level <= dac_level_adjust;
      dac_sample <= next_sample;
    end
  end

  // Timer paces pulse repetition and the alternating half period.
  txss_meter_timer u_timer (
    .ref_clk(ref_clk),
    .rst(rst),
    .enable(timer_ctl[TXSS_TCTL_EN_BIT]),
    .continuous(timer_ctl[TXSS_TCTL_CONT_BIT]),
    .restart(timer_restart),
    .interval(meter_interval),
    .tick(timer_tick),
    .running(timer_running)
  );

endmodule
`default_nettype wire

// [txss_monitor.sv]
`timescale 1ns/1ns
`default_nettype none
module txss_monitor
  import txss_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire txss_pair_s cu_pair,
  input wire txss_sym_s dac_symbol,
  input wire logic [7:0] dac_level,
  input wire logic signed [11:0] dac_sample
);
  default clocking dc @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  // Mode is mirrored two stages late to line up with the symbol it governs.
  logic [7:0] m0, m1, m2;
  logic signed [11:0] val;
  wire act = !m2[TXSS_MODE_OFF_BIT];
  wire [2:0] src = m2[2:0];
  wire txss_pair_s p = dac_symbol.pair;
  assign val = dac_symbol.zero ? 12'h000 : p.sign ? (p.mag ? 12'h001 :
    12'h003) : (p.mag ? 12'hfff : 12'hffd);
  always_ff @(posedge ref_clk)
  begin
    m0 <= rst ? TXSS_MODE_RESET : ((reg_wr && reg_addr == TXSS_ADDR_MODE) ?
      reg_wdata : m0);
    m1 <= rst ? TXSS_MODE_RESET : m0;
    m2 <= rst ? TXSS_MODE_RESET : m1;
  end
  chk_off_zero: assert property (!act |-> dac_symbol.zero)
    else $error("output not zero while off");
  chk_no_zero: assert property (act && src != TXSS_SRC_PULSE |->
    !dac_symbol.zero) else $error("zero level outside pulse mode");
  chk_two_level: assert property (act && src[2:1] == 2'b11 |->
    p.mag == 1'b0) else $error("inner level in two-level mode");
  chk_raw_pass: assert property (act && src == TXSS_SRC_DATA_RAW |->
    p == $past(cu_pair)) else $error("raw data not passed");
  chk_sign_pass: assert property (act && src == TXSS_SRC_DATA_2LVL |->
    p.sign == $past(cu_pair.sign)) else $error("sign not passed");
  chk_pulse_alone: assert property (act && src == TXSS_SRC_PULSE &&
    !dac_symbol.zero |-> p == m2[6:5] ##1 (dac_symbol.zero ||
    src != TXSS_SRC_PULSE)) else $error("pulse not isolated");
  chk_alt_level: assert property (act && src == TXSS_SRC_ALT |->
    p.mag == m2[TXSS_MODE_LVL_LSB]) else $error("alternating level wrong");
  chk_sample_scale: assert property (dac_sample ==
    val * $signed({4'h0, dac_level})) else $error("sample not scaled");
  chk_level_copy: assert property (reg_wr && reg_addr ==
    TXSS_ADDR_LEVEL |-> ##2 dac_level == $past(reg_wdata, 2))
    else $error("level word not applied");
endmodule
`default_nettype wire

// [txss_cu_model.sv]
`timescale 1ns/1ns
`default_nettype none
module txss_cu_model
  import txss_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  output txss_pair_s cu_pair
);
  // The pattern walks through all four pairs in a changing order.
  logic [4:0] cnt = 5'h00;
  assign cu_pair = cnt[1:0] ^ cnt[4:3];
  always @(posedge ref_clk)
    cnt <= rst ? 5'h00 : cnt + 5'h01;
endmodule
`default_nettype wire

// [txss_top_tb.sv]
`timescale 1ns/1ns
`default_nettype none
module txss_top_tb
  import txss_pkg::*;
;
  localparam logic [7:0] TRIM_WORD = 8'h5a;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata, dac_level, lvl;
  logic signed [11:0] dac_sample;
  txss_pair_s cu_pair, pc, pd;
  txss_pair_s det_pair = 2'b00;
  txss_sym_s dac_symbol;
  int n_mismatch = 0;
  int n_compared = 0;
  int cyc = 0;
  txss_top uut (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .cu_pair(cu_pair), .det_pair(det_pair),
    .factory_trim_pin(TRIM_WORD), .dac_symbol(dac_symbol),
    .dac_level(dac_level), .dac_sample(dac_sample));
  txss_cu_model cu (.ref_clk(ref_clk), .rst(rst), .cu_pair(cu_pair));
  initial
  begin
    forever #50 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk)
    det_pair <= {det_pair.mag, ~det_pair.sign};
  // Inputs as seen one symbol earlier, which is what the output reflects.
  always @(negedge ref_clk)
  begin
    pc <= cu_pair;
    pd <= det_pair;
  end
  task automatic close_out;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_mismatch++;
      close_out;
    end
  end
  task automatic cmp(input string nm, input logic [11:0] e,
    input logic [11:0] s);
    n_compared++;
    if (s !== e)
    begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    d = reg_rdata;
  endtask
  function automatic logic [11:0] vt(input txss_pair_s p);
    return p.sign ? (p.mag ? 12'h001 : 12'h003) : (p.mag ? 12'hfff :
      12'hffd);
  endfunction
  task automatic t_regs;
    logic [7:0] d;
    rd(TXSS_ADDR_MODE, d);
    cmp("mode", TXSS_MODE_RESET, d);
    rd(8'h77, d);
    cmp("unmapped", 12'h000, d);
    wr(TXSS_ADDR_TRIM, 8'h00);
    rd(TXSS_ADDR_TRIM, lvl);
    cmp("trim", TRIM_WORD, lvl);
    wr(TXSS_ADDR_LEVEL, lvl);
    rd(TXSS_ADDR_LEVEL, d);
    cmp("level", lvl, d);
    cmp("dac_level", lvl, dac_level);
  endtask
  task automatic t_direct(input logic [7:0] md);
    txss_pair_s p;
    wr(TXSS_ADDR_MODE, md);
    repeat (3) @(negedge ref_clk);
    repeat (12)
    begin
      @(negedge ref_clk);
      p = {pc.sign, pc.mag && md[2:0] != TXSS_SRC_DATA_2LVL};
      cmp("zero", md[4], dac_symbol.zero);
      if (!md[4])
        cmp("pair", p, dac_symbol.pair);
      cmp("sample", md[4] ? 12'h000 : vt(p) * lvl, dac_sample);
    end
  endtask
  task automatic t_scr(input logic [7:0] md);
    logic [22:0] h;
    logic [1:0] ib;
    int t;
    wr(TXSS_ADDR_MODE, md);
    t = md[3] ? TXSS_TAP_REMOTE : TXSS_TAP_LOCAL;
    h = 23'h00_0000;
    for (int k = 0; k < 40; k++)
    begin
      @(negedge ref_clk);
      ib = md[2:0] == 3'h1 ? pd : md[2:0] == 3'h5 ? pc : 2'b11;
      // The stream is self-synchronising, so history comes from the line.
      if (k > 26)
        cmp("sign", ib[1] ^ h[22] ^ h[t - 1], dac_symbol.pair.sign);
      h = {h[21:0], dac_symbol.pair.sign};
      if (k > 26 && md[2:0] != 3'h7)
        cmp("mag", ib[0] ^ h[22] ^ h[t - 1], dac_symbol.pair.mag);
      else if (k > 26)
        cmp("mag", 12'h000, dac_symbol.pair.mag);
      if (md[2:0] != 3'h7)
        h = {h[21:0], dac_symbol.pair.mag};
    end
  endtask
  task automatic t_timed(input logic [7:0] lo, input logic [7:0] hi,
    input logic [7:0] md, input int ncyc, input int nexp);
    txss_sym_s last;
    int n;
    logic [7:0] d;
    n = 0;
    wr(TXSS_ADDR_METER_LO, lo);
    wr(TXSS_ADDR_METER_HI, hi);
    wr(TXSS_ADDR_TIMER_CTL, 8'h03);
    wr(TXSS_ADDR_MODE, md);
    repeat (300) @(negedge ref_clk);
    last = dac_symbol;
    repeat (ncyc)
    begin
      @(negedge ref_clk);
      if (dac_symbol !== last)
        n++;
      last = dac_symbol;
      if (dac_symbol.zero === 1'b0)
        cmp("level", md[5], dac_symbol.pair.mag);
      if (dac_symbol.zero === 1'b0 && md[2:0] == TXSS_SRC_PULSE)
        cmp("pulse_sign", md[6], dac_symbol.pair.sign);
    end
    cmp("events", 12'h001, n >= nexp - 1 && n <= nexp + 1);
    rd(TXSS_ADDR_METER_LO, d);
    cmp("meter_lo", lo, d);
    rd(TXSS_ADDR_METER_HI, d);
    cmp("meter_hi", hi, d);
    rd(TXSS_ADDR_TIMER_CTL, d);
    cmp("timer_ctl", 12'h003, d);
    rd(TXSS_ADDR_STATUS, d);
    cmp("running", 12'h001, d[TXSS_STAT_RUN_BIT]);
  endtask
  initial
  begin
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    t_regs;
    t_direct(8'h02);
    t_direct(8'h06);
    t_direct(8'h12);
    for (int i = 0; i < 8; i++)
      t_scr(8'((i & 1) * 8 + (i >> 1) * 2 + 1));
    t_timed(8'h06, 8'h00, 8'h60, 60, 20);
    t_timed(8'h00, 8'h01, 8'h44, 1024, 4);
    close_out;
  end
endmodule
bind txss_top txss_monitor mon (.ref_clk(ref_clk), .rst(rst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .cu_pair(cu_pair), .dac_symbol(dac_symbol), .dac_level(dac_level),
  .dac_sample(dac_sample));
`default_nettype wire
